// ===== inc/tec_pkg.sv
// Constants and types shared by the timer/event counter design files
package tec_pkg;
    // ----------------------------------------------------------------
    // Register map (byte addresses on the 32-bit bus)
    // ----------------------------------------------------------------
    localparam int ADDR_W = 4;
    localparam logic [3:0] OFS_PRELOAD = 4'h0;
    localparam logic [3:0] OFS_CONTROL = 4'h4;
    localparam logic [3:0] OFS_STATUS = 4'h8;
    localparam logic [3:0] OFS_MASK = 4'hc;
    // ----------------------------------------------------------------
    // Control register fields
    // ----------------------------------------------------------------
    localparam int BIT_PSC_LO = 0;
    localparam int BIT_PSC_HI = 2;
    localparam int BIT_EDGE = 3;
    localparam int BIT_RUN = 4;
    localparam int BIT_MODE_LO = 6;
    localparam int BIT_MODE_HI = 7;
    localparam logic [7:0] CTRL_RESET = 8'h00;
    localparam logic [7:0] CTRL_WMASK = 8'hdf;
    // ----------------------------------------------------------------
    // Counter, status and bus answers
    // ----------------------------------------------------------------
    localparam logic [7:0] CNT_FULL = 8'hff;
    localparam logic [7:0] CNT_RESET = 8'h00;
    localparam logic [7:0] CNT_STEP = 8'h01;
    localparam int ST_OVF = 0;
    localparam logic [7:0] STATUS_MASK = 8'h01;
    localparam logic [7:0] MASK_RESET = 8'h00;
    localparam int PSC_STAGES = 8;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef enum logic [1:0] {
        TEC_MODE_NONE = 2'b00,
        TEC_MODE_EVENT = 2'b01,
        TEC_MODE_TIMER = 2'b10,
        TEC_MODE_PULSE = 2'b11
    } tec_mode_t;

    typedef enum logic [1:0] {
        TEC_PW_WAIT = 2'b00,
        TEC_PW_MEASURE = 2'b01
    } tec_pw_t;
endpackage : tec_pkg

// ===== logic/tec_pin_sync.sv
// Shared input pin synchroniser and edge detector
`timescale 1ns/1ps
module tec_pin_sync (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic pin,
    output logic rise,
    output logic fall
);
    logic meta;
    logic stable;
    logic last;

    // First stage feeds only the second one
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            meta <= 1'b0;
            stable <= 1'b0;
            last <= 1'b0;
        end else begin
            meta <= pin;
            stable <= meta;
            last <= stable;
        end
    end

    // One cycle per edge [RULE19]
    assign rise = stable & ~last;
    assign fall = ~stable & last;
endmodule : tec_pin_sync

// ===== logic/tec_prescaler.sv
// Eight-stage prescaler giving one tick per selected division period
`timescale 1ns/1ps
module tec_prescaler (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [2:0] psc_sel,
    output logic tick
);
    logic [tec_pkg::PSC_STAGES-1:0] stage;
    logic tap_last;
    logic tap;

    assign tap = stage[psc_sel];

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            stage <= '0;
            tap_last <= 1'b0;
        end else begin
            stage <= stage + 1'b1;
            tap_last <= tap;
        end
    end

    // Counter steps on the high to low transition of the divided clock
    assign tick = tap_last & ~tap; // [RULE3] [RULE4]
endmodule : tec_prescaler

// ===== logic/tec_timer.sv
// Eight-bit timer / event counter with an AXI4-Lite register slave
//
// How it works
// RULE1: 8-bit up-counter with timer, event count and pulse width modes.
// RULE2: Writing the counter register loads preload; reading returns live count.
// RULE3: Timer and pulse width modes count prescaled system clock ticks.
// RULE4: Control bits 0-2 pick prescale ratio; ignored in event mode.
// RULE5: Event mode counts pin edges of the polarity chosen by edge select.
// RULE6: Counting from preload to ff; next count overflows and flags interrupt.
// RULE7: Overflow reloads counter from preload and counting carries on.
// RULE8: Software clears preload to 00 for the full 256-count range.
// RULE9: Preload has no reset value; unknown until software writes it.
// RULE10: While stopped, a preload write also goes straight into the counter.
// RULE11: While running, a new preload reaches the counter at next overflow.
// RULE12: Control bit 4 is the run bit: set runs, clear stops.
// RULE13: Control bit 3 selects active pin edge in event and pulse modes.
// RULE14: Software selects timer mode when the pin is plain I/O.
// RULE15: Software fully programs control before using the counter.
// RULE16: Mode bits {hi,lo}: 10 timer, 01 event, 11 pulse width.
// RULE17: Pulse mode counts between start edge and return; run bit self-clears.
// RULE18: Event mode keeps counting in power-down; overflow raises wake-up.
// RULE19: Pin is synchronised, each edge gives one single-cycle count enable.
`timescale 1ns/1ps
module tec_timer (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [tec_pkg::ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [tec_pkg::ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic shared_input_pin,
    input wire logic power_down,
    output logic irq,
    output logic wake
);
    // ----------------------------------------------------------------
    // Declarations
    // ----------------------------------------------------------------
    logic [7:0] counter;
    logic [7:0] counter_preload;
    logic [7:0] counter_control;
    logic [7:0] status;
    logic [7:0] mask;
    logic [tec_pkg::ADDR_W-1:0] aw_addr;
    logic [7:0] w_data;
    logic w_lane0;
    logic aw_hold;
    logic w_hold;
    logic do_write;
    logic addr_ok;
    logic pre_we;
    logic ctrl_we;
    logic status_we;
    logic mask_we;
    logic ar_fire;
    logic [31:0] next_rdata;
    logic [1:0] next_rresp;
    tec_pkg::tec_mode_t mode;
    tec_pkg::tec_pw_t pw_state;
    logic run_bit;
    logic edge_select;
    logic pin_rise;
    logic pin_fall;
    logic tick;
    logic start_edge;
    logic stop_edge;
    logic pw_stop;
    logic count_en;
    logic overflow;

    // ----------------------------------------------------------------
    // Submodules
    // ----------------------------------------------------------------
    tec_pin_sync u_sync (
        .aclk(aclk),
        .aresetn(aresetn),
        .pin(shared_input_pin),
        .rise(pin_rise),
        .fall(pin_fall)
    );

    tec_prescaler u_psc (
        .aclk(aclk),
        .aresetn(aresetn),
        .psc_sel(counter_control[tec_pkg::BIT_PSC_HI:tec_pkg::BIT_PSC_LO]),
        .tick(tick)
    );

    // ----------------------------------------------------------------
    // AXI4-Lite write path
    // ----------------------------------------------------------------
    assign s_axi_awready = ~aw_hold & ~s_axi_bvalid;
    assign s_axi_wready = ~w_hold & ~s_axi_bvalid;
    assign do_write = aw_hold & w_hold & ~s_axi_bvalid;
    assign addr_ok = (aw_addr == tec_pkg::OFS_PRELOAD)
                   | (aw_addr == tec_pkg::OFS_CONTROL)
                   | (aw_addr == tec_pkg::OFS_STATUS)
                   | (aw_addr == tec_pkg::OFS_MASK);
    // Registers are 8 bits wide, so only byte lane 0 carries a write
    assign pre_we = do_write & w_lane0 & (aw_addr == tec_pkg::OFS_PRELOAD);
    assign ctrl_we = do_write & w_lane0 & (aw_addr == tec_pkg::OFS_CONTROL);
    assign status_we = do_write & w_lane0 & (aw_addr == tec_pkg::OFS_STATUS);
    assign mask_we = do_write & w_lane0 & (aw_addr == tec_pkg::OFS_MASK);

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_hold <= 1'b0;
            aw_addr <= '0;
        end else if (s_axi_awvalid && s_axi_awready) begin
            aw_hold <= 1'b1;
            aw_addr <= s_axi_awaddr;
        end else if (do_write) begin
            aw_hold <= 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            w_hold <= 1'b0;
            w_data <= '0;
            w_lane0 <= 1'b0;
        end else if (s_axi_wvalid && s_axi_wready) begin
            w_hold <= 1'b1;
            w_data <= s_axi_wdata[7:0];
            w_lane0 <= s_axi_wstrb[0];
        end else if (do_write) begin
            w_hold <= 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= tec_pkg::RESP_OKAY;
        end else if (do_write) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= addr_ok ? tec_pkg::RESP_OKAY
                                   : tec_pkg::RESP_SLVERR;
        end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    // ----------------------------------------------------------------
    // AXI4-Lite read path
    // ----------------------------------------------------------------
    assign s_axi_arready = ~s_axi_rvalid;
    assign ar_fire = s_axi_arvalid & s_axi_arready;

    always_comb begin
        next_rdata = '0;
        next_rresp = tec_pkg::RESP_OKAY;
        case (s_axi_araddr)
            tec_pkg::OFS_PRELOAD: next_rdata[7:0] = counter; // [RULE2]
            tec_pkg::OFS_CONTROL: next_rdata[7:0] = counter_control;
            tec_pkg::OFS_STATUS: next_rdata[7:0] = status;
            tec_pkg::OFS_MASK: next_rdata[7:0] = mask;
            default: next_rresp = tec_pkg::RESP_SLVERR;
        endcase
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= '0;
            s_axi_rresp <= tec_pkg::RESP_OKAY;
        end else if (ar_fire) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= next_rdata;
            s_axi_rresp <= next_rresp;
        end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end

    // ----------------------------------------------------------------
    // Control and preload registers
    // ----------------------------------------------------------------
    assign mode = tec_pkg::tec_mode_t'({counter_control[tec_pkg::BIT_MODE_HI],
                                        counter_control[tec_pkg::BIT_MODE_LO]});
    assign run_bit = counter_control[tec_pkg::BIT_RUN]; // [RULE12]
    assign edge_select = counter_control[tec_pkg::BIT_EDGE];

    // A software write beats the hardware self-clear in the same cycle
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            counter_control <= tec_pkg::CTRL_RESET;
        end else if (ctrl_we) begin
            counter_control <= w_data & tec_pkg::CTRL_WMASK;
        end else if (pw_stop) begin
            counter_control[tec_pkg::BIT_RUN] <= 1'b0; // [RULE17]
        end
    end

    // No reset: contents stay unknown until the first write
    always_ff @(posedge aclk) begin
        if (pre_we) begin
            counter_preload <= w_data; // [RULE2] [RULE9]
        end
    end

    // ----------------------------------------------------------------
    // Pulse width measurement sequence
    // ----------------------------------------------------------------
    // Low edge select: start on falling, stop on return high
    assign start_edge = edge_select ? pin_rise : pin_fall; // [RULE13]
    assign stop_edge = edge_select ? pin_fall : pin_rise;
    assign pw_stop = (pw_state == tec_pkg::TEC_PW_MEASURE) & stop_edge;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            pw_state <= tec_pkg::TEC_PW_WAIT;
        end else begin
            case (pw_state)
                tec_pkg::TEC_PW_WAIT: begin
                    if (run_bit && mode == tec_pkg::TEC_MODE_PULSE
                        && start_edge) begin
                        pw_state <= tec_pkg::TEC_PW_MEASURE; // [RULE17]
                    end
                end
                tec_pkg::TEC_PW_MEASURE: begin
                    if (stop_edge || !run_bit
                        || mode != tec_pkg::TEC_MODE_PULSE) begin
                        pw_state <= tec_pkg::TEC_PW_WAIT; // [RULE17]
                    end
                end
                default: pw_state <= tec_pkg::TEC_PW_WAIT;
            endcase
        end
    end

    // ----------------------------------------------------------------
    // Counter
    // ----------------------------------------------------------------
    // The system clock is held in power-down, so only pin events count
    always_comb begin
        count_en = 1'b0;
        case (mode)
            tec_pkg::TEC_MODE_TIMER:
                count_en = run_bit & tick & ~power_down; // [RULE3]
            tec_pkg::TEC_MODE_EVENT: // [RULE5] [RULE18]
                count_en = run_bit & (edge_select ? pin_fall
                                                  : pin_rise);
            tec_pkg::TEC_MODE_PULSE:
                count_en = run_bit & tick & ~power_down
                         & (pw_state == tec_pkg::TEC_PW_MEASURE); // [RULE17]
            default: count_en = 1'b0; // [RULE16]
        endcase
    end

    assign overflow = count_en & (counter == tec_pkg::CNT_FULL); // [RULE6]

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            counter <= tec_pkg::CNT_RESET;
        end else if (pre_we && !run_bit) begin
            counter <= w_data; // [RULE10]
        end else if (overflow) begin
            counter <= counter_preload; // [RULE7] [RULE11]
        end else if (count_en) begin
            counter <= counter + tec_pkg::CNT_STEP; // [RULE1]
        end
    end

    // ----------------------------------------------------------------
    // Interrupt status, mask and wake-up
    // ----------------------------------------------------------------
    // A new overflow wins over a write-one-to-clear in the same cycle
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            status <= '0;
        end else begin
            status <= ((status & ~(status_we ? w_data : '0))
                      | {7'h00, overflow}) & tec_pkg::STATUS_MASK; // [RULE6]
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            mask <= tec_pkg::MASK_RESET;
        end else if (mask_we) begin
            mask <= w_data & tec_pkg::STATUS_MASK;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            wake <= 1'b0;
        end else begin
            wake <= overflow & power_down; // [RULE18]
        end
    end

    assign irq = |(status & mask);

    // ----------------------------------------------------------------
    // Assertions
    // ----------------------------------------------------------------
    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);

    ovf_reload_a: assert property ( // [RULE7]
        overflow |=> counter == $past(counter_preload))
        else $error("overflow did not reload the preload value");
    count_step_a: assert property ( // [RULE1]
        count_en && !overflow && !pre_we |=> counter == $past(counter) + 8'h01)
        else $error("counter did not step by one");
    stopped_load_a: assert property ( // [RULE10]
        pre_we && !run_bit |=> counter == $past(w_data))
        else $error("stopped preload write missed the counter");
    deferred_load_a: assert property ( // [RULE11]
        pre_we && run_bit && !count_en |=> counter == $past(counter))
        else $error("running preload write disturbed the counter");
    stop_hold_a: assert property ( // [RULE12]
        !run_bit |-> !count_en)
        else $error("counter enabled while stopped");
    ovf_flag_a: assert property ( // [RULE6]
        overflow && mask[tec_pkg::ST_OVF] |=> status[tec_pkg::ST_OVF] && irq)
        else $error("overflow did not raise the interrupt");
    pulse_stop_a: assert property ( // [RULE17]
        pw_stop && !ctrl_we |=> !run_bit ##1 !count_en)
        else $error("run bit did not clear at pulse end");
    event_edge_a: assert property ( // [RULE5]
        mode == tec_pkg::TEC_MODE_EVENT && run_bit && !edge_select
        && pin_rise && counter != tec_pkg::CNT_FULL
        |=> counter == $past(counter) + 8'h01)
        else $error("rising pin edge not counted");
    timer_tick_a: assert property ( // [RULE3]
        mode == tec_pkg::TEC_MODE_TIMER && !tick && !pre_we |=> $stable(counter))
        else $error("timer counted without a prescaler tick");
    pd_wake_a: assert property ( // [RULE18]
        overflow && power_down |=> wake ##1 !wake || $past(overflow))
        else $error("overflow in power-down gave no wake pulse");

    timer_ovf_c: cover property (
        mode == tec_pkg::TEC_MODE_TIMER && overflow);
    event_ovf_c: cover property (
        mode == tec_pkg::TEC_MODE_EVENT && overflow && power_down);
    pulse_done_c: cover property (pw_stop ##1 !run_bit);
    clear_c: cover property (status_we && status[tec_pkg::ST_OVF]);
endmodule : tec_timer

// ===== dv/tec_pin_src.sv
// Model of the external event or pulse source on the timer input pin
`timescale 1ns/1ps
module tec_pin_src (
    input wire logic aclk,
    input wire logic noise,
    output logic pin
);
    initial pin = 1'b0;
    // ----------------------------------------------------------------
    // Plain I/O activity
    // ----------------------------------------------------------------
    // Toggles faster than the counter may see; harmless only in timer mode
    always @(posedge aclk) begin
        if (noise) begin
            pin <= ~pin;
        end
    end
    // ----------------------------------------------------------------
    // Framed stimulus
    // ----------------------------------------------------------------
    task automatic level(input logic v);
        @(posedge aclk);
        pin <= v;
    endtask : level
    // Each level is held for w >= 2 clocks so the synchroniser sees it
    task automatic pulses(input logic idle, input int n, input int w);
        repeat (n) begin
            @(posedge aclk);
            pin <= ~idle;
            repeat (w) @(posedge aclk);
            pin <= idle;
            repeat (w - 1) @(posedge aclk);
        end
    endtask : pulses
endmodule : tec_pin_src

// ===== dv/tb_top.sv
// Self-checking testbench for the timer / event counter
`timescale 1ns/1ps
module tb_top;
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic [3:0] s_axi_awaddr = 4'h0;
    logic [3:0] s_axi_araddr = 4'h0;
    logic [31:0] s_axi_wdata = 32'h0;
    logic [3:0] s_axi_wstrb = 4'hf;
    logic s_axi_awvalid = 1'b0;
    logic s_axi_wvalid = 1'b0;
    logic s_axi_bready = 1'b0;
    logic s_axi_arvalid = 1'b0;
    logic s_axi_rready = 1'b0;
    logic power_down = 1'b0;
    logic noise = 1'b0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
    logic s_axi_rvalid, shared_input_pin, irq, wake;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic [31:0] s_axi_rdata, rd_data;
    logic [1:0] wq[$];
    logic [34:0] rq[$];
    logic [34:0] re;
    int n_mismatch = 0;
    int total_checks = 0;
    int n_wake = 0;
    integer seed = 32'h27b33527;
    int w;
    logic [7:0] d;
    longint t0, t1;

    always #12.5 aclk = ~aclk;

    tec_timer tec_timer_i (.aclk(aclk), .aresetn(aresetn),
        .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
        .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
        .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
        .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
        .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
        .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
        .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
        .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
        .s_axi_rready(s_axi_rready), .shared_input_pin(shared_input_pin),
        .power_down(power_down), .irq(irq), .wake(wake));

    tec_pin_src tec_pin_src_i (.aclk(aclk), .noise(noise),
        .pin(shared_input_pin));

    // ----------------------------------------------------------------
    // Reporting
    // ----------------------------------------------------------------
    task automatic stop_test;
        if (n_mismatch == 0 && total_checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : stop_test

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : check

    // Longest legal wait is one timer period at the slowest prescale
    task automatic tick(inout int n);
        @(posedge aclk);
        n++;
        if (n > 6000) begin
            n_mismatch++;
            stop_test();
        end
    endtask : tick

    // ----------------------------------------------------------------
    // Register bus master
    // ----------------------------------------------------------------
    task automatic wr(input logic [3:0] a, input logic [7:0] v,
                      input logic [1:0] r = tec_pkg::RESP_OKAY);
        int n;
        logic aw_ok, w_ok;
        wq.push_back(r);
        n = 0;
        aw_ok = 1'b0;
        w_ok = 1'b0;
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= {24'h0, v};
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do begin
            tick(n);
            if (!aw_ok && s_axi_awready) begin
                aw_ok = 1'b1;
                s_axi_awvalid <= 1'b0;
            end
            if (!w_ok && s_axi_wready) begin
                w_ok = 1'b1;
                s_axi_wvalid <= 1'b0;
            end
        end while (!(aw_ok && w_ok));
        do tick(n); while (s_axi_bvalid !== 1'b1);
        s_axi_bready <= 1'b0;
    endtask : wr

    task automatic rd(input logic [3:0] a, input logic [7:0] v,
                      input logic care = 1'b1,
                      input logic [1:0] r = tec_pkg::RESP_OKAY);
        int n;
        rq.push_back({care, r, 24'h0, v});
        n = 0;
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do tick(n); while (s_axi_arready !== 1'b1);
        s_axi_arvalid <= 1'b0;
        do tick(n); while (s_axi_rvalid !== 1'b1);
        rd_data = s_axi_rdata;
        s_axi_rready <= 1'b0;
    endtask : rd

    task automatic wait_irq;
        int n;
        n = 0;
        while (irq !== 1'b1) tick(n);
    endtask : wait_irq

    // ----------------------------------------------------------------
    // Response monitor
    // ----------------------------------------------------------------
    always @(posedge aclk) begin
        if (wake === 1'b1) n_wake++;
        if (s_axi_bvalid && s_axi_bready) begin
            check({30'h0, s_axi_bresp}, {30'h0, wq.pop_front()});
        end
        if (s_axi_rvalid && s_axi_rready) begin
            re = rq.pop_front();
            check({30'h0, s_axi_rresp}, {30'h0, re[33:32]});
            if (re[34]) check(s_axi_rdata, re[31:0]);
        end
    end

    // ----------------------------------------------------------------
    // Stimulus
    // ----------------------------------------------------------------
    initial begin
        repeat (5) @(posedge aclk);
        aresetn <= 1'b1;
        rd(tec_pkg::OFS_CONTROL, 8'h00);
        rd(tec_pkg::OFS_STATUS, 8'h00);
        rd(tec_pkg::OFS_MASK, 8'h00);
        wr(tec_pkg::OFS_CONTROL, 8'hff);
        rd(tec_pkg::OFS_CONTROL, 8'hdf);
        wr(tec_pkg::OFS_CONTROL, 8'h00);
        wr(4'h2, 8'h55, tec_pkg::RESP_SLVERR);
        rd(4'h6, 8'h00, 1'b1, tec_pkg::RESP_SLVERR);
        d = 8'($random(seed));
        wr(tec_pkg::OFS_PRELOAD, d);
        rd(tec_pkg::OFS_PRELOAD, d);
        // Event counting, stopped then running
        w = 2 + int'({$random(seed)} % 4);
        wr(tec_pkg::OFS_PRELOAD, 8'hfd);
        wr(tec_pkg::OFS_CONTROL, 8'h40);
        tec_pin_src_i.pulses(1'b0, 2, w);
        repeat (6) @(posedge aclk);
        rd(tec_pkg::OFS_PRELOAD, 8'hfd);
        wr(tec_pkg::OFS_CONTROL, 8'h50);
        tec_pin_src_i.pulses(1'b0, 2, w);
        repeat (6) @(posedge aclk);
        rd(tec_pkg::OFS_PRELOAD, 8'hff);
        wr(tec_pkg::OFS_PRELOAD, 8'h10);
        rd(tec_pkg::OFS_PRELOAD, 8'hff);
        rd(tec_pkg::OFS_STATUS, 8'h00);
        tec_pin_src_i.pulses(1'b0, 1, w);
        repeat (6) @(posedge aclk);
        rd(tec_pkg::OFS_PRELOAD, 8'h10);
        rd(tec_pkg::OFS_STATUS, 8'h01);
        check({31'h0, irq}, 32'h0);
        wr(tec_pkg::OFS_MASK, 8'h01);
        check({31'h0, irq}, 32'h1);
        // A write without byte lane 0 must leave the mask alone
        s_axi_wstrb <= 4'he;
        wr(tec_pkg::OFS_MASK, 8'h00);
        s_axi_wstrb <= 4'hf;
        check({31'h0, irq}, 32'h1);
        wr(tec_pkg::OFS_STATUS, 8'h01);
        check({31'h0, irq}, 32'h0);
        // Falling edges; the idle rise before them must not count
        wr(tec_pkg::OFS_CONTROL, 8'h58);
        tec_pin_src_i.level(1'b1);
        tec_pin_src_i.pulses(1'b1, 3, 2 + int'({$random(seed)} % 4));
        repeat (6) @(posedge aclk);
        rd(tec_pkg::OFS_PRELOAD, 8'h13);
        check(32'(n_wake), 32'h0);
        wr(tec_pkg::OFS_CONTROL, 8'h48);
        wr(tec_pkg::OFS_PRELOAD, 8'hff);
        power_down <= 1'b1;
        wr(tec_pkg::OFS_CONTROL, 8'h58);
        tec_pin_src_i.pulses(1'b1, 1, w);
        repeat (6) @(posedge aclk);
        check(32'(n_wake), 32'h1);
        check({31'h0, irq}, 32'h1);
        rd(tec_pkg::OFS_PRELOAD, 8'hff);
        power_down <= 1'b0;
        wr(tec_pkg::OFS_STATUS, 8'h01);
        // Timer: overflow period is 16 counts of the prescaled clock
        noise <= 1'b1;
        for (int s = 0; s < 8; s++) begin
            wr(tec_pkg::OFS_CONTROL, 8'h80 | 8'(s));
            wr(tec_pkg::OFS_PRELOAD, 8'hf0);
            wr(tec_pkg::OFS_STATUS, 8'h01);
            wr(tec_pkg::OFS_CONTROL, 8'h90 | 8'(s));
            wait_irq();
            t0 = $time;
            wr(tec_pkg::OFS_STATUS, 8'h01);
            wait_irq();
            t1 = $time;
            check(32'((t1 - t0) / 25), 32'(16 << (s + 1)));
        end
        noise <= 1'b0;
        // Pulse width, both polarities, single shot
        for (int e = 0; e < 2; e++) begin
            wr(tec_pkg::OFS_CONTROL, 8'hc0 | 8'(e << 3));
            tec_pin_src_i.level(e == 0);
            repeat (4) @(posedge aclk);
            wr(tec_pkg::OFS_PRELOAD, 8'h00);
            wr(tec_pkg::OFS_CONTROL, 8'hd0 | 8'(e << 3));
            tec_pin_src_i.pulses(e == 0, 1, 40);
            repeat (6) @(posedge aclk);
            rd(tec_pkg::OFS_CONTROL, 8'hc0 | 8'(e << 3));
            rd(tec_pkg::OFS_PRELOAD, 8'h00, 1'b0);
            check({31'h0, rd_data >= 18 && rd_data <= 22}, 32'h1);
            tec_pin_src_i.pulses(e == 0, 1, 10);
            repeat (6) @(posedge aclk);
            rd(tec_pkg::OFS_PRELOAD, rd_data[7:0]);
            rd(tec_pkg::OFS_CONTROL, 8'hc0 | 8'(e << 3));
        end
        stop_test();
    end
endmodule : tb_top
